// *** hdl/fht_pkg.sv ***
package fht_pkg;
  localparam int          CLK_NS        = 100;
  localparam int          CLAMP_ON_NS   = 200;
  localparam int          SWITCH_ON_NS  = 2000;
  localparam int          SS_PERIOD_NS  = 10000;
  localparam int          HS_GAP_NS     = 30000;
  localparam int          HS_MIN_NS     = 20000;
  localparam int          HS_MAX_NS     = 40000;
  localparam int          SKIP_LO_NS    = 83000;
  localparam int          SKIP_HI_NS    = 143000;
  localparam int          LL_NS0        = 80;
  localparam int          LL_NS1        = 100;
  localparam int          LL_NS2        = 120;
  localparam int          LL_NS3        = 140;
  localparam int          HL_NS         = 500;
  localparam int          HL_SMALL_NS   = 430;
  localparam int          PF_NS0        = 300;
  localparam int          PF_NS1        = 400;
  localparam int          PF_NS2        = 500;
  localparam int          RESTART_ON_MS = 82;
  localparam int          AR_OFF_MS     = 1000;
  localparam int          CYC_PER_MS    = 1000000 / CLK_NS;
  localparam logic [7:0]  LINE_HI_Q     = 8'hd7;
  localparam logic [7:0]  LINE_HYST_Q   = 8'h1e;
  localparam logic [7:0]  LINE_LO_Q     = LINE_HI_Q - LINE_HYST_Q;
  localparam logic [7:0]  CLAMP_CYC     = 8'((CLAMP_ON_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0]  ON_CYC        = 8'((SWITCH_ON_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [10:0] SS_OFF_CYC    = 11'((SS_PERIOD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [10:0] HS_MIN_CYC    = 11'((HS_MIN_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [10:0] HS_MAX_CYC    = 11'(HS_MAX_NS / CLK_NS);
  localparam logic [10:0] SKIP_LO_CYC   = 11'((SKIP_LO_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [10:0] SKIP_HI_CYC   = 11'(SKIP_HI_NS / CLK_NS);
  localparam logic [7:0]  LL_CYC0       = 8'((LL_NS0 + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0]  LL_CYC1       = 8'((LL_NS1 + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0]  LL_CYC2       = 8'((LL_NS2 + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0]  LL_CYC3       = 8'((LL_NS3 + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0]  HL_CYC        = 8'((HL_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0]  HL_SMALL_CYC  = 8'((HL_SMALL_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0]  PF_CYC0       = 8'((PF_NS0 + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0]  PF_CYC1       = 8'((PF_NS1 + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0]  PF_CYC2       = 8'((PF_NS2 + CLK_NS - 1) / CLK_NS);

  typedef enum logic [4:0] {
    ST_WAIT    = 5'h01,
    ST_SELF    = 5'h02,
    ST_SLAVE   = 5'h04,
    ST_RESTART = 5'h08,
    ST_FAULT   = 5'h10
  } fht_st_t;

  typedef enum logic [3:0] {
    PH_IDLE  = 4'h1,
    PH_CLAMP = 4'h2,
    PH_DELAY = 4'h4,
    PH_ON    = 4'h8
  } fht_ph_t;

  typedef struct packed {
    fht_st_t     st;
    fht_ph_t     ph;
    logic [23:0] tmr;
    logic [7:0]  cnt;
    logic [10:0] gap;
    logic [10:0] last;
    logic        seen1;
    logic [1:0]  code;
    logic        code_ok;
    logic        hi;
    logic        dly_hi;
    logic        clamp;
    logic        sw;
    logic        sec;
    logic        ar;
    logic        ss;
  } fht_state_t;
endpackage

// *** hdl/fht_timing.sv ***
`timescale 1ns/10ps
// Summary of operation
// - low-line delay from code: 80-140 ns
// - fixed high-line delay 500 or 430 ns
// - line hysteresis selects high or low delay
// - pfc variant: delay 300/400/500 ns at either line
// - wait first, then self switching, then requests only
// - no requests in on-time: auto-restart
// - primary holds control until handshake succeeds
// - wait restart on-time, listening for requests
// - two requests ~30 us apart: slave mode
// - no requests in wait: self switching
// - requests 83-143 us after conduction inhibited
// - start-up: softstart frequency, 75% limit
// - resume after stop returns to start-up
// - clamp pulse, selected delay, then switch
module fht_timing
  import fht_pkg::*;
#(
  parameter int unsigned RESTART_CYC = RESTART_ON_MS * CYC_PER_MS,
  parameter int unsigned AR_OFF_CYC  = AR_OFF_MS * CYC_PER_MS
) (
  input  wire logic       ref_clk_i,
  input  wire logic       nrst_i,
  input  wire logic       variant_pfc_i,
  input  wire logic       small_part_i,
  input  wire logic [1:0] delay_code_i,
  input  wire logic [7:0] line_sense_q_i,
  input  wire logic       req_i,
  input  wire logic       fault_i,
  output logic            clamp_drive_out_o,
  output logic            power_switch_o,
  output logic            secondary_ctrl_o,
  output logic            auto_restart_o,
  output logic            softstart_o,
  output logic            current_cap75_o
);

  fht_state_t s_r;
  fht_state_t s_nxt;
  logic       hs_ok;
  logic       fire;
  logic       skip;

  function automatic logic [7:0] dly_sel(input logic pfc, input logic sml,
                                         input logic hi, input logic [1:0] code);
    logic [7:0] d;
    d = HL_CYC;
    if (pfc) begin
      case (code)
        2'h0:    d = PF_CYC0;
        2'h1:    d = PF_CYC1;
        default: d = PF_CYC2;
      endcase
    end else if (hi) begin
      d = sml ? HL_SMALL_CYC : HL_CYC;
    end else begin
      case (code)
        2'h0:    d = LL_CYC0;
        2'h1:    d = LL_CYC1;
        2'h2:    d = LL_CYC2;
        default: d = LL_CYC3;
      endcase
    end
    return d;
  endfunction

  always_comb begin
    s_nxt = s_r;
    hs_ok = 1'b0;
    fire  = 1'b0;
    if (!s_r.code_ok) begin
      s_nxt.code    = delay_code_i;
      s_nxt.code_ok = 1'b1;
    end
    if (line_sense_q_i > LINE_HI_Q) begin
      s_nxt.hi = 1'b1;
    end else if (line_sense_q_i <= LINE_LO_Q) begin
      s_nxt.hi = 1'b0;
    end
    if (s_r.gap != 11'h7ff) begin
      s_nxt.gap = s_r.gap + 11'h001;
    end
    if (s_r.last != 11'h7ff) begin
      s_nxt.last = s_r.last + 11'h001;
    end
    s_nxt.tmr = s_r.tmr + 24'h000001;
    skip = (s_r.last >= SKIP_LO_CYC) && (s_r.last < SKIP_HI_CYC);
    if (req_i) begin
      hs_ok = s_r.seen1 && (s_r.gap >= HS_MIN_CYC) && (s_r.gap <= HS_MAX_CYC);
      s_nxt.seen1 = 1'b1;
      s_nxt.gap   = 11'h000;
    end else if (s_r.gap > HS_MAX_CYC) begin
      s_nxt.seen1 = 1'b0;
    end
    case (s_r.st)
      ST_WAIT: begin
        if (hs_ok) begin
          s_nxt.st  = ST_SLAVE;
          s_nxt.tmr = 24'h000000;
          fire      = 1'b1;
        end else if (s_r.tmr >= 24'(RESTART_CYC - 1)) begin
          s_nxt.st  = ST_SELF;
          s_nxt.tmr = 24'h000000;
        end
      end
      ST_SELF: begin
        if (hs_ok) begin
          s_nxt.st  = ST_SLAVE;
          s_nxt.tmr = 24'h000000;
          fire      = 1'b1;
        end else if (req_i) begin
          s_nxt.tmr = 24'h000000;
        end else if (s_r.tmr >= 24'(RESTART_CYC - 1)) begin
          s_nxt.st  = ST_RESTART;
          s_nxt.tmr = 24'h000000;
        end else if (s_r.last >= SS_OFF_CYC) begin
          fire = 1'b1;
        end
      end
      ST_SLAVE: begin
        if (req_i) begin
          s_nxt.tmr = 24'h000000;
          fire      = !skip;
        end else if (s_r.tmr >= 24'(RESTART_CYC - 1)) begin
          s_nxt.st  = ST_RESTART;
          s_nxt.tmr = 24'h000000;
        end
      end
      ST_RESTART: begin
        if (s_r.tmr >= 24'(AR_OFF_CYC - 1)) begin
          s_nxt.st    = ST_WAIT;
          s_nxt.tmr   = 24'h000000;
          s_nxt.seen1 = req_i;
        end
      end
      ST_FAULT: begin
        s_nxt.tmr = 24'h000000;
        if (!fault_i) begin
          s_nxt.st    = ST_WAIT;
          s_nxt.seen1 = req_i;
        end
      end
      default: begin
        s_nxt.st = ST_WAIT;
      end
    endcase
    case (s_r.ph)
      PH_IDLE: begin
        if (fire) begin
          s_nxt.ph  = PH_CLAMP;
          s_nxt.cnt = CLAMP_CYC - 8'h01;
        end
      end
      PH_CLAMP: begin
        if (s_r.cnt == 8'h00) begin
          s_nxt.ph     = PH_DELAY;
          s_nxt.dly_hi = s_r.hi;
          s_nxt.cnt    = dly_sel(variant_pfc_i, small_part_i, s_r.hi, s_r.code) - 8'h01;
        end else begin
          s_nxt.cnt = s_r.cnt - 8'h01;
        end
      end
      PH_DELAY: begin
        if (s_r.cnt == 8'h00) begin
          s_nxt.ph  = PH_ON;
          s_nxt.cnt = ON_CYC - 8'h01;
        end else begin
          s_nxt.cnt = s_r.cnt - 8'h01;
        end
      end
      PH_ON: begin
        if (s_r.cnt == 8'h00) begin
          s_nxt.ph   = PH_IDLE;
          s_nxt.last = 11'h000;
        end else begin
          s_nxt.cnt = s_r.cnt - 8'h01;
        end
      end
      default: begin
        s_nxt.ph = PH_IDLE;
      end
    endcase
    if (fault_i) begin
      s_nxt.st    = ST_FAULT;
      s_nxt.seen1 = 1'b0;
    end
    if (s_nxt.st != ST_SLAVE && s_nxt.st != ST_SELF) begin
      s_nxt.ph = PH_IDLE;
    end
    s_nxt.clamp = (s_nxt.ph == PH_CLAMP);
    s_nxt.sw    = (s_nxt.ph == PH_ON);
    s_nxt.sec   = (s_nxt.st == ST_SLAVE);
    s_nxt.ar    = (s_nxt.st == ST_RESTART);
    s_nxt.ss    = (s_nxt.st == ST_WAIT) || (s_nxt.st == ST_SELF);
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      s_r         <= '0;
      s_r.st      <= ST_WAIT;
      s_r.ph      <= PH_IDLE;
      s_r.gap     <= 11'h7ff;
      s_r.last    <= 11'h7ff;
      s_r.ss      <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign clamp_drive_out_o = s_r.clamp;
  assign power_switch_o    = s_r.sw;
  assign secondary_ctrl_o  = s_r.sec;
  assign auto_restart_o    = s_r.ar;
  assign softstart_o       = s_r.ss;
  assign current_cap75_o   = s_r.ss;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  chk_clamp_width: assert property (
    disable iff (!nrst_i || fault_i)
    $rose(clamp_drive_out_o) |-> clamp_drive_out_o [*2] ##1 !clamp_drive_out_o
  ) else $error("clamp pulse width wrong");

  chk_no_overlap: assert property (
    !(clamp_drive_out_o && power_switch_o)
  ) else $error("clamp and switch overlap");

  chk_low_delay: assert property (
    disable iff (!nrst_i || fault_i)
    ($fell(clamp_drive_out_o) && !variant_pfc_i && !s_r.dly_hi && !fault_i)
    |-> !power_switch_o ##[1:2] $rose(power_switch_o)
  ) else $error("low-line delay out of range");

  chk_high_delay: assert property (
    disable iff (!nrst_i || fault_i)
    ($fell(clamp_drive_out_o) && !variant_pfc_i && s_r.dly_hi && !fault_i)
    |-> !power_switch_o [*5] ##1 power_switch_o
  ) else $error("high-line delay wrong");

  chk_pfc_delay: assert property (
    disable iff (!nrst_i || fault_i)
    ($fell(clamp_drive_out_o) && variant_pfc_i && !fault_i)
    |-> !power_switch_o ##[3:5] $rose(power_switch_o)
  ) else $error("pfc delay out of range");

  chk_line_hyst: assert property (
    (s_r.hi && line_sense_q_i > LINE_LO_Q) |=> s_r.hi
  ) else $error("high-line dropped early");

  chk_line_rise: assert property (
    (line_sense_q_i > LINE_HI_Q) |=> s_r.hi
  ) else $error("high-line not entered");

  chk_code_held: assert property (
    $past(s_r.code_ok) |-> $stable(s_r.code)
  ) else $error("delay code changed");

  chk_slave_req: assert property (
    ($rose(clamp_drive_out_o) && secondary_ctrl_o) |-> $past(req_i)
  ) else $error("slave pulse without request");

  chk_skip_band: assert property (
    ($rose(clamp_drive_out_o) && secondary_ctrl_o && $past(secondary_ctrl_o))
    |-> !($past(s_r.last) >= SKIP_LO_CYC && $past(s_r.last) < SKIP_HI_CYC)
  ) else $error("request in skip band served");

  chk_handover: assert property (
    $rose(secondary_ctrl_o) |-> $past(softstart_o) && $past(req_i)
  ) else $error("handover without handshake");

  chk_wait_quiet: assert property (
    (s_r.st == ST_WAIT) |-> !clamp_drive_out_o && !power_switch_o
  ) else $error("switching during wait");

  chk_fault_stop: assert property (
    fault_i |=> !power_switch_o && !clamp_drive_out_o ##0 (s_r.st == ST_FAULT)
  ) else $error("fault did not stop switching");

  chk_fault_resume: assert property (
    ($past(s_r.st == ST_FAULT) && !$past(fault_i)) |-> (s_r.st == ST_WAIT) && softstart_o
  ) else $error("no start-up after fault");

  cov_handshake: cover property ($rose(secondary_ctrl_o));
  cov_restart:   cover property ($rose(auto_restart_o));
  cov_skip:      cover property (req_i && secondary_ctrl_o && skip);
  cov_high_line: cover property ($rose(power_switch_o) && s_r.dly_hi);

endmodule

// *** tb/fht_peer.sv ***
`timescale 1ns/10ps
module fht_peer #(
  parameter int unsigned MIN_OFF = 50,
  parameter int unsigned SS_CYC  = 200,
  parameter int unsigned QR_CYC  = 100
) (
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        run_i,
  input  wire logic [11:0] period_i,
  input  wire logic        power_switch_i,
  input  wire logic        out_low_i,
  output logic             req_o,
  output logic             sync_rectifier_gate_o
);
  logic [11:0] cnt_r;
  logic [1:0]  hs_r;
  logic [3:0]  miss_r;
  logic        ans_r;
  logic        sw_d_r;
  logic [11:0] per;
  logic [11:0] ss_r;
  logic [11:0] slow;
  logic        mute_r;
  assign slow = (ss_r < 12'(SS_CYC)) ? 12'(SS_CYC) - ss_r : 12'h000;
  assign per = (period_i + slow < 12'(MIN_OFF)) ? 12'(MIN_OFF) : period_i + slow;
  always_ff @(posedge ref_clk_i) begin
    req_o <= 1'b0;
    sw_d_r <= power_switch_i;
    if (power_switch_i) ans_r <= 1'b1;
    if (sw_d_r && !power_switch_i) sync_rectifier_gate_o <= 1'b1;
    if (sync_rectifier_gate_o && cnt_r == 12'h064) sync_rectifier_gate_o <= 1'b0;
    if (!nrst_i || !run_i) begin
      cnt_r <= 12'h000;
      hs_r <= 2'h0;
      miss_r <= 4'h0;
      ans_r <= 1'b0;
      ss_r <= 12'h000;
      mute_r <= 1'b0;
      sync_rectifier_gate_o <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 12'h001;
      if (hs_r == 2'h2 && ss_r < 12'(SS_CYC)) ss_r <= ss_r + 12'h001;
      // regulation aborts ramp after qr setup
      if (hs_r == 2'h2 && !out_low_i && ss_r >= 12'(QR_CYC)) ss_r <= 12'(SS_CYC);
      // low output at timer end: go silent
      if (hs_r == 2'h2 && out_low_i && ss_r == 12'(SS_CYC - 1)) mute_r <= 1'b1;
      if (!mute_r && (hs_r == 2'h0 || (hs_r == 2'h1 && cnt_r == 12'h12b) ||
                      (hs_r == 2'h2 && cnt_r >= per - 1))) begin
        req_o <= 1'b1;
        cnt_r <= 12'h000;
        hs_r <= (hs_r == 2'h2) ? 2'h2 : hs_r + 2'h1;
        sync_rectifier_gate_o <= 1'b0;
        if (hs_r == 2'h2) begin
          ans_r <= 1'b0;
          miss_r <= ans_r ? 4'h0 : miss_r + 4'h1;
          if (!ans_r && miss_r == 4'h7) hs_r <= 2'h0;
        end
      end
    end
  end
endmodule

// *** tb/fht_timing_tb.sv ***
`timescale 1ns/10ps
module fht_timing_tb;
  import fht_pkg::*;
  localparam int unsigned RCYC = 2000;
  localparam int unsigned ACYC = 500;
  logic        ref_clk_i      = 1'b0;
  logic        nrst_i         = 1'b0;
  logic        variant_pfc_i  = 1'b0;
  logic        small_part_i   = 1'b0;
  logic [1:0]  delay_code_i   = 2'h0;
  logic [7:0]  line_sense_q_i = 8'h00;
  logic        fault_i        = 1'b0;
  logic        run            = 1'b0;
  logic        out_low        = 1'b0;
  logic [11:0] period         = 12'h0c8;
  logic        req_i, clamp_drive_out_o, power_switch_o, secondary_ctrl_o;
  logic        auto_restart_o, softstart_o, current_cap75_o;
  logic [7:0]  lv [4]         = '{8'hc0, 8'hb9, 8'hd0, 8'he0};
  logic        lh [4]         = '{1'b1, 1'b0, 1'b0, 1'b1};
  int          bad_count      = 0;
  int          tests_run      = 0;
  int          cw = 0, sw = 0, g = 0, idl = 0, n_req = 0, n_clamp = 0;
  int          clamp_w, sw_w, gap_w, idle_w, r0, c0;
  always #50 ref_clk_i = ~ref_clk_i;
  fht_timing #(.RESTART_CYC(RCYC), .AR_OFF_CYC(ACYC)) fht_timing_inst (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .variant_pfc_i(variant_pfc_i),
    .small_part_i(small_part_i), .delay_code_i(delay_code_i),
    .line_sense_q_i(line_sense_q_i), .req_i(req_i), .fault_i(fault_i),
    .clamp_drive_out_o(clamp_drive_out_o), .power_switch_o(power_switch_o),
    .secondary_ctrl_o(secondary_ctrl_o), .auto_restart_o(auto_restart_o),
    .softstart_o(softstart_o), .current_cap75_o(current_cap75_o));
  fht_peer fht_peer_inst (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .run_i(run), .period_i(period),
    .power_switch_i(power_switch_o), .out_low_i(out_low), .req_o(req_i),
    .sync_rectifier_gate_o());
  // pulse width and gap monitor
  always @(posedge ref_clk_i) begin
    if (req_i === 1'b1) n_req++;
    if (clamp_drive_out_o === 1'b1) begin
      if (cw == 0) begin
        idle_w = idl;
        n_clamp++;
      end
      cw++;
      g = 0;
    end else begin
      if (cw != 0) clamp_w = cw;
      cw = 0;
    end
    if (power_switch_o === 1'b1) begin
      if (sw == 0) gap_w = g;
      sw++;
      idl = 0;
    end else begin
      if (sw != 0) sw_w = sw;
      sw = 0;
      idl++;
      if (clamp_drive_out_o !== 1'b1) g++;
    end
  end
  function automatic int exp_gap(input logic pfc, input logic sm, input logic [1:0] c,
                                 input logic hi);
    int ns;
    if (pfc) ns = (c == 2'h0) ? PF_NS0 : (c == 2'h1) ? PF_NS1 : PF_NS2;
    else if (hi) ns = sm ? HL_SMALL_NS : HL_NS;
    else ns = (c == 2'h0) ? LL_NS0 : (c == 2'h1) ? LL_NS1 : (c == 2'h2) ? LL_NS2 : LL_NS3;
    return (ns + CLK_NS - 1) / CLK_NS;
  endfunction
  function automatic logic pick(input int w);
    return (w == 0) ? secondary_ctrl_o : (w == 1) ? auto_restart_o :
           (w == 2) ? softstart_o : clamp_drive_out_o;
  endfunction
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t %s: got %0d expected %0d", $time, what, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic wait_hi(input int w, input int lim);
    for (int i = 0; i <= lim; i++) begin
      step(1);
      if (pick(w) === 1'b1) return;
    end
    bad_count++;
    $display("ERROR %0t wait %0d timed out", $time, w);
    summarize;
  endtask
  task automatic do_reset(input logic [1:0] c, input logic pfc, input logic [7:0] ln);
    @(posedge ref_clk_i);
    nrst_i <= 1'b0;
    run <= 1'b0;
    delay_code_i <= c;
    variant_pfc_i <= pfc;
    small_part_i <= 1'($urandom % 2);
    line_sense_q_i <= ln;
    period <= 12'h0c8;
    step(10);
    @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    run <= 1'b1;
    step(1);
  endtask
  initial begin
    void'($urandom(3999));
    step(10);
    check(32'(softstart_o), 1, "reset softstart");
    check(32'(current_cap75_o), 1, "reset cap");
    check(32'(secondary_ctrl_o), 0, "reset slave");
    for (int v = 0; v < 3; v++) begin
      for (int k = 0; k < 4; k++) begin
        do_reset(2'(k), (v == 2), (v == 1) ? 8'(216 + $urandom % 40) : 8'($urandom % 186));
        check(32'(secondary_ctrl_o), 0, "before handshake");
        wait_hi(0, 1000);
        @(posedge ref_clk_i) delay_code_i <= 2'($urandom);
        step(450);
        check(gap_w, exp_gap(v == 2, small_part_i, 2'(k), v == 1), "delay");
        check(clamp_w, (CLAMP_ON_NS + CLK_NS - 1) / CLK_NS, "clamp width");
        check(sw_w, (SWITCH_ON_NS + CLK_NS - 1) / CLK_NS, "switch width");
      end
    end
    $display("test delay table done");
    do_reset(2'h0, 1'b0, 8'he0);
    wait_hi(0, 1000);
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk_i) line_sense_q_i <= lv[i];
      step(450);
      check(gap_w, exp_gap(1'b0, small_part_i, 2'h0, lh[i]), "hysteresis");
    end
    $display("test hysteresis done");
    @(posedge ref_clk_i) period <= 12'h3e8;
    step(1100);
    r0 = n_req;
    c0 = n_clamp;
    step(10000);
    check(32'((n_clamp - c0) + 3 <= (n_req - r0)), 1, "skip band");
    @(posedge ref_clk_i) period <= 12'h5dc;
    step(1600);
    r0 = n_req;
    c0 = n_clamp;
    step(15000);
    check(32'((n_req - r0) - (n_clamp - c0) <= 1 && n_req - r0 >= 9), 1, "outside band");
    $display("test skip done");
    @(posedge ref_clk_i) run <= 1'b0;
    wait_hi(1, RCYC + 100);
    check(32'(secondary_ctrl_o), 0, "restart slave");
    wait_hi(2, ACYC + 100);
    c0 = n_clamp;
    step(RCYC - 200);
    check(n_clamp - c0, 0, "wait silent");
    wait_hi(3, 400);
    step(1500);
    check(32'(idle_w >= SS_PERIOD_NS / CLK_NS), 1, "self spacing");
    check(32'(current_cap75_o), 1, "self cap");
    $display("test restart done");
    @(posedge ref_clk_i) run <= 1'b1;
    wait_hi(0, 1000);
    r0 = n_req;
    c0 = n_clamp;
    step(4000);
    check(32'((n_clamp - c0) <= (n_req - r0) + 1), 1, "slave follows");
    $display("test takeover done");
    @(posedge ref_clk_i) fault_i <= 1'b1;
    run <= 1'b0;
    step(3);
    check(32'(secondary_ctrl_o), 0, "fault slave");
    c0 = n_clamp;
    step(500);
    check(n_clamp - c0, 0, "fault quiet");
    @(posedge ref_clk_i) fault_i <= 1'b0;
    step(2);
    check(32'(softstart_o), 1, "resume startup");
    check(32'(secondary_ctrl_o), 0, "resume primary");
    @(posedge ref_clk_i) run <= 1'b1;
    wait_hi(0, 1000);
    check(32'(secondary_ctrl_o), 1, "rehandshake");
    $display("test fault done");
    @(posedge ref_clk_i) run <= 1'b0;
    out_low <= 1'b1;
    step(2);
    @(posedge ref_clk_i) run <= 1'b1;
    step(1500);
    check(32'(secondary_ctrl_o), 1, "short handover");
    step(1100);
    check(32'(auto_restart_o), 1, "short restart");
    check(32'(secondary_ctrl_o), 0, "short released");
    $display("test short done");
    summarize;
  end
endmodule
